// ===== psf_pkg.sv
package psf_pkg;

  // ----------------------------------------------------------------
  // Clock and device timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_RS_NS = 35;
  localparam int T_WPW_NS = 35;
  localparam int T_RPW_NS = 35;
  localparam int T_A_NS = 35;
  localparam int T_RT_NS = 35;
  localparam int T_FLAG_NS = 45;
  localparam int SYNC_CYC = 3;

  // Least times round up, never below one cycle
  function automatic int psf_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : psf_cyc

  localparam logic [3:0] RS_CYC = 4'(psf_cyc(T_RS_NS));
  localparam logic [3:0] WR_CYC = 4'(psf_cyc(T_WPW_NS));
  localparam logic [3:0] RD_CYC = 4'(psf_cyc(T_RPW_NS) > psf_cyc(T_A_NS)
                                     ? psf_cyc(T_RPW_NS) + SYNC_CYC
                                     : psf_cyc(T_A_NS) + SYNC_CYC);
  localparam logic [3:0] RT_CYC = 4'(psf_cyc(T_RT_NS));
  localparam logic [3:0] SETTLE_CYC = 4'(psf_cyc(T_FLAG_NS) + SYNC_CYC);

  // ----------------------------------------------------------------
  // Widths, register map and fields
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int FLAG_W = 6;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WDATA = 8'h04;
  localparam logic [7:0] ADDR_RCMD = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_RDATA = 8'h10;

  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_RETX_BIT = 1;
  localparam int CTRL_IFS_BIT = 2;
  localparam int CTRL_OFS_BIT = 3;
  localparam logic [1:0] FMT_RESET = 2'h3;

  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RVALID_BIT = 1;
  localparam int ST_WREF_BIT = 2;
  localparam int ST_RREF_BIT = 3;
  localparam int ST_FLAG_LSB = 4;

  // Flag vector order, all active low at the pins
  localparam int FL_EMPTY = 0;
  localparam int FL_EMPTY_P1 = 1;
  localparam int FL_ALMOST = 2;
  localparam int FL_HALF = 3;
  localparam int FL_FULL_M1 = 4;
  localparam int FL_FULL = 5;

  typedef enum logic [2:0] {
    PSF_IDLE = 3'b000,
    PSF_RST = 3'b001,
    PSF_WR = 3'b010,
    PSF_RD = 3'b011,
    PSF_RT = 3'b100,
    PSF_SETTLE = 3'b101
  } psf_state_type;

endpackage : psf_pkg

// ===== psf_host.sv
`timescale 1ns/1ps
module psf_host import psf_pkg::*; (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic reset_n_o,
  output logic write_n_o,
  output logic read_n_o,
  output logic first_load_retransmit_n_o,
  output logic expansion_in_n_o,
  output logic input_format_select_o,
  output logic output_format_select_o,
  output logic [DATA_W-1:0] parallel_data_in_o,
  output logic parallel_data_in_oe_n_o,
  input wire logic [DATA_W-1:0] parallel_data_out_i,
  input wire logic full_flag_n_i,
  input wire logic full_minus_one_flag_n_i,
  input wire logic almost_boundary_flag_n_i,
  input wire logic half_full_flag_n_i,
  input wire logic empty_plus_one_flag_n_i,
  input wire logic empty_flag_n_i
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SY_W = DATA_W + FLAG_W;

  logic [SY_W-1:0] sy1_r, sy2_r, sy3_r, filt_r;
  wire logic [SY_W-1:0] pins = {full_flag_n_i, full_minus_one_flag_n_i,
                                half_full_flag_n_i, almost_boundary_flag_n_i,
                                empty_plus_one_flag_n_i, empty_flag_n_i,
                                parallel_data_out_i};

  always_ff @(posedge ref_clk_i) begin
    sy1_r <= pins;
    sy2_r <= sy1_r;
    sy3_r <= sy2_r;
  end

  wire logic [SY_W-1:0] sy_agree = ~(sy2_r ^ sy3_r);

  // A bit changes only once the last two stages agree
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      filt_r <= '1;
    end else begin
      filt_r <= (sy3_r & sy_agree) | (filt_r & ~sy_agree);
    end
  end

  wire logic [FLAG_W-1:0] flags_n = filt_r[SY_W-1:DATA_W];
  wire logic [DATA_W-1:0] q_filt = filt_r[DATA_W-1:0];
  wire logic dev_full = ~flags_n[FL_FULL];
  wire logic dev_empty = ~flags_n[FL_EMPTY];

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  psf_state_type state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic rst_pend_r, rt_pend_r, wr_pend_r, rd_pend_r;
  logic [1:0] fmt_r;
  logic [DATA_W-1:0] wdata_r, rx_r;
  logic rvalid_r, wref_r, rref_r, dev_init_r;
  logic rd_last_r;

  wire logic wr_ctrl = wr_i && (addr_i == ADDR_CTRL);
  wire logic wr_wdata = wr_i && (addr_i == ADDR_WDATA);
  wire logic wr_rcmd = wr_i && (addr_i == ADDR_RCMD) && wdata_i[0];
  wire logic rd_rdata = rd_i && (addr_i == ADDR_RDATA);
  wire logic busy = (state_r != PSF_IDLE) || rst_pend_r || rt_pend_r
                    || wr_pend_r || rd_pend_r;

  wire logic st_idle = (state_r == PSF_IDLE);
  wire logic take_rst = st_idle && rst_pend_r;
  wire logic take_rt = st_idle && !rst_pend_r && rt_pend_r;
  wire logic take_wr = st_idle && !rst_pend_r && !rt_pend_r && wr_pend_r;
  wire logic take_rd = st_idle && !rst_pend_r && !rt_pend_r && !wr_pend_r
                       && rd_pend_r;
  wire logic wr_go = take_wr && !dev_full;
  wire logic rd_go = take_rd && !dev_empty;
  wire logic rd_cap = (state_r == PSF_RD) && (cnt_r == 4'h1);

  wire logic [31:0] status_word = {
    {(32 - ST_FLAG_LSB - FLAG_W){1'b0}}, flags_n,
    rref_r, wref_r, rvalid_r, busy};

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_o <= 32'h0;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CTRL: rdata_o <= {28'h0, fmt_r[1], fmt_r[0], 2'h0};
        ADDR_WDATA: rdata_o <= {23'h0, wdata_r};
        ADDR_STATUS: rdata_o <= status_word;
        ADDR_RDATA: rdata_o <= {23'h0, rx_r};
        default: rdata_o <= 32'h0;
      endcase
    end
  end

  // Power-up reset request is pending from the start
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rst_pend_r <= 1'b1;
      rt_pend_r <= 1'b0;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      fmt_r <= FMT_RESET;
      wdata_r <= '0;
    end else begin
      rst_pend_r <= (rst_pend_r && !take_rst)
                    || (wr_ctrl && wdata_i[CTRL_RESET_BIT]);
      rt_pend_r <= (rt_pend_r && !take_rt)
                   || (wr_ctrl && wdata_i[CTRL_RETX_BIT]);
      rd_pend_r <= (rd_pend_r && !take_rd) || wr_rcmd;
      wr_pend_r <= (wr_pend_r && !take_wr) || (wr_wdata && !wr_pend_r);
      if (wr_ctrl) begin
        fmt_r <= {wdata_i[CTRL_OFS_BIT], wdata_i[CTRL_IFS_BIT]};
      end
      // A word written while one is still pending is ignored
      if (wr_wdata && !wr_pend_r) begin
        wdata_r <= wdata_i[DATA_W-1:0];
      end
    end
  end

  // Sticky status bits: hardware set wins over the software clear
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rvalid_r <= 1'b0;
      rd_last_r <= 1'b0;
      wref_r <= 1'b0;
      rref_r <= 1'b0;
      rx_r <= '0;
      dev_init_r <= 1'b0;
    end else begin
      // Filter lags the pins by four edges, so Q is taken one cycle late
      rd_last_r <= rd_cap;
      rvalid_r <= rd_last_r || (rvalid_r && !rd_rdata);
      wref_r <= (take_wr && dev_full) || (wref_r && !rd_rdata);
      rref_r <= (take_rd && dev_empty) || (rref_r && !rd_rdata);
      if (rd_last_r) begin
        rx_r <= q_filt;
      end
      if (state_r == PSF_RST) begin
        dev_init_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Strobe sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      PSF_IDLE: begin
        if (take_rst) begin
          state_nxt = PSF_RST;
          cnt_nxt = RS_CYC;
        end else if (take_rt) begin
          state_nxt = PSF_RT;
          cnt_nxt = RT_CYC;
        end else if (wr_go) begin
          state_nxt = PSF_WR;
          cnt_nxt = WR_CYC;
        end else if (rd_go) begin
          state_nxt = PSF_RD;
          cnt_nxt = RD_CYC;
        end
      end
      PSF_RST, PSF_WR, PSF_RD, PSF_RT: begin
        if (cnt_r == 4'h1) begin
          state_nxt = PSF_SETTLE;
          cnt_nxt = SETTLE_CYC;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      PSF_SETTLE: begin
        // Lets the flags pass the synchronisers before the next decision
        if (cnt_r == 4'h1) begin
          state_nxt = PSF_IDLE;
        end else begin
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      default: begin
        state_nxt = PSF_IDLE;
        cnt_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_r <= PSF_IDLE;
      cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Device pins
  // ----------------------------------------------------------------
  // Strobes stay high through reset and retransmit by construction
  assign reset_n_o = (state_r != PSF_RST);
  assign write_n_o = (state_r != PSF_WR);
  assign read_n_o = (state_r != PSF_RD);
  assign first_load_retransmit_n_o = (state_r != PSF_RT);
  // Only single-device operation is supported, so retransmit is legal
  assign expansion_in_n_o = 1'b0;
  assign input_format_select_o = fmt_r[0];
  assign output_format_select_o = fmt_r[1];
  assign parallel_data_in_o = wdata_r;
  // Released in serial input mode, where the device drives these pins
  assign parallel_data_in_oe_n_o = !fmt_r[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_read_low;
    (!read_n_o) [*4];
  endsequence

  sequence s_read_done;
    read_n_o ##1 rvalid_r;
  endsequence

  a_reset_strobes_high: assert property (
    !reset_n_o |-> (write_n_o && read_n_o))
    else $error("strobe low during device reset");

  a_reset_pulse_width: assert property (
    $fell(reset_n_o) |=> reset_n_o ##1 (!write_n_o == 1'b0))
    else $error("device reset pulse has wrong width");

  a_write_after_init: assert property (
    !write_n_o |-> dev_init_r)
    else $error("write before device reset");

  a_write_not_full: assert property (
    $fell(write_n_o) |-> $past(flags_n[FL_FULL]))
    else $error("write started while full");

  a_read_not_empty: assert property (
    $fell(read_n_o) |-> $past(flags_n[FL_EMPTY]))
    else $error("read started while empty");

  a_read_capture: assert property (
    $fell(read_n_o) |-> s_read_low ##1 s_read_done)
    else $error("read pulse width or capture wrong");

  a_retx_strobes_high: assert property (
    !first_load_retransmit_n_o |-> (write_n_o && read_n_o && reset_n_o))
    else $error("strobe low during retransmit");

  a_retx_pulse: assert property (
    $fell(first_load_retransmit_n_o) |=> first_load_retransmit_n_o
      ##1 (state_r == PSF_SETTLE))
    else $error("retransmit pulse has wrong width");

  a_data_driven_write: assert property (
    !write_n_o |-> (!parallel_data_in_oe_n_o && input_format_select_o))
    else $error("write strobe without driven data");

  a_single_device: assert property (
    $fell(first_load_retransmit_n_o) |-> !expansion_in_n_o)
    else $error("retransmit outside single-device mode");

endmodule : psf_host

// ===== psf_dev_model.sv
`timescale 1ns/1ps
module psf_dev_model #(
  parameter int DEPTH = 16
) (
  input wire logic reset_n_i,
  input wire logic write_n_i,
  input wire logic read_n_i,
  input wire logic rt_n_i,
  input wire logic xi_n_i,
  input wire logic ifs_i,
  input wire logic [8:0] d_i,
  output logic [8:0] q_o,
  output logic full_n_o,
  output logic fm1_n_o,
  output logic almost_n_o,
  output logic half_n_o,
  output logic ep1_n_o,
  output logic empty_n_o
);
  logic [8:0] mem [DEPTH];
  logic [8:0] qd = 9'h000;
  int wptr = 0;
  int rptr = 0;
  int wslot = 0;
  bit wgo = 1'b0;
  int cnt;

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  assign cnt = wptr - rptr;
  always @(negedge reset_n_i) begin
    wptr = 0;
    rptr = 0;
  end
  // Slot is claimed on the falling edge, data lands on the rising edge
  always @(negedge write_n_i) begin
    if (reset_n_i && ifs_i && cnt < DEPTH) begin
      wslot = wptr % DEPTH;
      wptr = wptr + 1;
      wgo = 1'b1;
    end
  end
  always @(posedge write_n_i) begin
    if (wgo) begin
      mem[wslot] = d_i;
      wgo = 1'b0;
    end
  end
  always @(negedge read_n_i) begin
    if (reset_n_i && cnt > 0) begin
      qd = mem[rptr % DEPTH];
      rptr = rptr + 1;
    end
  end
  always @(negedge rt_n_i) begin
    if (reset_n_i && !xi_n_i) begin
      rptr = 0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // A released bus shows the inverse, never a stale word
  assign q_o = read_n_i ? ~qd : qd;
  assign full_n_o = (cnt != DEPTH);
  assign fm1_n_o = (cnt < DEPTH - 1);
  assign half_n_o = (cnt <= DEPTH / 2);
  assign almost_n_o = !(cnt < DEPTH / 8 || cnt > DEPTH - DEPTH / 8);
  assign ep1_n_o = (cnt > 1);
  assign empty_n_o = (cnt != 0);
endmodule : psf_dev_model

// ===== tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
  import psf_pkg::*;
  localparam int DEPTH = 16;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] rdata, e, m;
  logic rst_n, wr_n, rd_n, rt_n, xi_n, ifs, ofs, oe_n;
  logic [8:0] dq, qd;
  logic [5:0] fl;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [8:0] words[$];
  logic [8:0] hist[$];
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int seed;

  always #25 clk = ~clk;

  psf_host dut (.ref_clk_i(clk), .reset_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .reset_n_o(rst_n), .write_n_o(wr_n), .read_n_o(rd_n),
    .first_load_retransmit_n_o(rt_n), .expansion_in_n_o(xi_n),
    .input_format_select_o(ifs), .output_format_select_o(ofs),
    .parallel_data_in_o(dq), .parallel_data_in_oe_n_o(oe_n),
    .parallel_data_out_i(qd), .full_flag_n_i(fl[5]),
    .full_minus_one_flag_n_i(fl[4]), .almost_boundary_flag_n_i(fl[2]),
    .half_full_flag_n_i(fl[3]), .empty_plus_one_flag_n_i(fl[1]),
    .empty_flag_n_i(fl[0]));

  psf_dev_model #(.DEPTH(DEPTH)) dev (.reset_n_i(rst_n), .write_n_i(wr_n),
    .read_n_i(rd_n), .rt_n_i(rt_n), .xi_n_i(xi_n), .ifs_i(ifs), .d_i(dq),
    .q_o(qd), .full_n_o(fl[5]), .fm1_n_o(fl[4]), .almost_n_o(fl[2]),
    .half_n_o(fl[3]), .ep1_n_o(fl[1]), .empty_n_o(fl[0]));

  // ----------------------------------------------------------------
  // Watchers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      if (m != 32'h0) `CHK(rdata & m, e & m)
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (!rst && (!rst_n || !rt_n)) `CHK({wr_n, rd_n}, 2'b11)
    if (cycles == 40000) begin
      n_errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bus_wr
  // A zero mask marks a read that is not compared, such as a poll whose data the caller inspects itself
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] x,
                        input logic [31:0] k);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(x);
    msk_q.push_back(k);
    @(posedge clk);
    rd <= 1'b0;
  endtask : bus_rd
  task automatic op(input logic [7:0] a, input logic [31:0] d);
    int i;
    bus_wr(a, d);
    for (i = 0; i < 60; i++) begin
      bus_rd(ADDR_STATUS, 32'h0, 32'h0);
      @(negedge clk);
      if (rdata[ST_BUSY_BIT] === 1'b0) break;
    end
    `CHK(rdata[ST_BUSY_BIT], 1'b0)
  endtask : op
  function automatic logic [31:0] flg(input int c);
    flg = {22'h0, c != DEPTH, c < DEPTH - 1, c <= DEPTH / 2,
      !(c < DEPTH / 8 || c > DEPTH - DEPTH / 8), c > 1, c != 0, 4'h0};
  endfunction : flg
  task automatic wr_word(input int c);
    logic [8:0] w;
    w = 9'($urandom);
    words.push_back(w);
    hist.push_back(w);
    op(ADDR_WDATA, {23'h0, w});
    bus_rd(ADDR_STATUS, flg(c), 32'h3f4);
  endtask : wr_word
  task automatic rd_word(input int c);
    op(ADDR_RCMD, 32'h1);
    bus_rd(ADDR_RDATA, {23'h0, words.pop_front()}, 32'h1ff);
    bus_rd(ADDR_STATUS, flg(c), 32'h3fe);
  endtask : rd_word
  task automatic refused_read;
    op(ADDR_RCMD, 32'h1);
    bus_rd(ADDR_STATUS, flg(0) | 32'h8, 32'h3f8);
    bus_rd(ADDR_RDATA, 32'h0, 32'h0);
  endtask : refused_read
  task automatic complete_run;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = $urandom(75104);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    op(ADDR_RCMD, 32'h0);
    bus_rd(ADDR_STATUS, flg(0), 32'h3f0);
    `CHK(xi_n, 1'b0)
    refused_read();
    for (int c = 1; c <= DEPTH; c++) wr_word(c);
    op(ADDR_WDATA, 32'h1ab);
    bus_rd(ADDR_STATUS, flg(DEPTH) | 32'h4, 32'h3f4);
    bus_rd(ADDR_RDATA, 32'h0, 32'h0);
    for (int c = DEPTH - 1; c >= 0; c--) rd_word(c);
    refused_read();
    op(ADDR_CTRL, 32'hd);
    bus_rd(ADDR_STATUS, flg(0), 32'h3f0);
    hist.delete();
    for (int c = 1; c <= 3; c++) wr_word(c);
    rd_word(2);
    rd_word(1);
    op(ADDR_CTRL, 32'he);
    words = hist;
    bus_rd(ADDR_STATUS, flg(3), 32'h3f0);
    for (int c = 2; c >= 0; c--) rd_word(c);
    op(ADDR_CTRL, 32'h8);
    `CHK({ofs, ifs, oe_n}, 3'b101)
    bus_rd(ADDR_CTRL, 32'h8, 32'hc);
    op(ADDR_CTRL, 32'h4);
    `CHK({ofs, ifs, oe_n}, 3'b010)
    op(ADDR_CTRL, 32'hc);
    `CHK({ofs, ifs, oe_n}, 3'b110)
    bus_rd(8'h20, 32'h0, 32'hffffffff);
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule : tb_top
